// ==== verilog/accsl_map.svh ====
// address, register offsets, field layouts and timing counts of the sensor serial port
`ifndef ACCSL_MAP_SVH
`define ACCSL_MAP_SVH
`define ACCSL_DEV_ADDR 7'h15
`define ACCSL_DIR_READ 1'b1
`define ACCSL_REG_XLOW 8'h00
`define ACCSL_REG_XHIGH 8'h01
`define ACCSL_REG_YLOW 8'h02
`define ACCSL_REG_YHIGH 8'h03
`define ACCSL_REG_STATUS 8'h06
`define ACCSL_REG_SLEEP 8'h07
`define ACCSL_REG_FACTORY 8'h08
`define ACCSL_REG_DETECT 8'h0a
`define ACCSL_REG_IDENT 8'h10
`define ACCSL_HIGH_PAD 4'h0
`define ACCSL_CTRL_RESET 8'h00
`define ACCSL_BYTE_BITS 4'h8
`define ACCSL_SCL_HALF 4'h3
`define ACCSL_MCLK_NS 50
`define ACCSL_LOW_LIMIT_MS 10
`define ACCSL_LOW_LIMIT_CYC ((`ACCSL_LOW_LIMIT_MS * 1000000) / `ACCSL_MCLK_NS)
`endif

// ==== verilog/accsl_pkg.sv ====
// state and command types of the two ends of the sensor serial link
package accsl_pkg;
  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ACK, SL_WRITE, SL_READ, SL_RACK
  } accsl_slave_state_type;
  typedef enum logic [3:0] {
    MS_IDLE, MS_START, MS_BIT, MS_ACK, MS_STOP, MS_RESTART
  } accsl_master_state_type;
  typedef enum logic [1:0] {
    ACCSL_CMD_WRITE, ACCSL_CMD_READ
  } accsl_cmd_type;
endpackage

// ==== verilog/accsl_if.sv ====
// two-wire link between the sensor port and its bus master
`timescale 1ns/1ps
interface accsl_if;
  logic scl_out;
  logic scl_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // wired-and with pull-ups
  assign scl = scl_oe ? scl_out : 1'b1;
  assign sda = (sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_s_out, output sda_s_oe);
  modport master (input scl, input sda, output scl_out, output scl_oe, output sda_m_out, output sda_m_oe);
endinterface

// ==== verilog/accsl_slave.sv ====
// slave end: serial port and register decoder of the acceleration sensor
`timescale 1ns/1ps
`include "accsl_map.svh"
// Contract
// (R01) answer only bus address 0010101b
// (R02) slave only; clock in, open-drain data
// (R03) start/stop seen as data edges, clock high
// (R04) bytes msb first, ninth pulse acknowledges
// (R05) receiver holds data low over ninth pulse
// (R06) master may stop after missing acknowledge
// (R07) master nacks last read byte; release data
// (R08) repeated start restarts address reception
// (R09) first byte: address then direction bit
// (R10) acknowledge match, then send or receive
// (R11) first written byte loads register pointer
// (R12) further bytes stored, pointer advances
// (R13) master sets pointer, then restarts reading
// (R14) reads send pointed register, then advance
// (R15) interrupt low normally, high on change
// (R16) interrupt released on internal fault
// (R17) master never holds both lines low long
// (R18) decode 00,01,02,03,06,07,08,0a,10
// (R19) x result low at 00, high 01
// (R20) y result low at 02, high 03
// (R21) 07,08,0a write-only; 06,10 read-only
// (R22) x low byte bits map straight
// (R23) upper-bits registers pad bits 7:4 zero
// (R24) unmapped ignored on write, zero on read
module accsl_slave #(
  parameter logic [7:0] IDENT_VALUE = 8'h81 // arbitrary identity value
) (
  input wire logic MCLK,
  input wire logic RSTN,
  accsl_if.device LINK,
  input wire logic [11:0] X_ACCEL_RESULT,
  input wire logic [11:0] Y_ACCEL_RESULT,
  input wire logic [7:0] STATUS_IN,
  input wire logic INT_EVENT,
  input wire logic FAULT,
  output logic [7:0] SLEEP_CONTROL,
  output logic [7:0] FACTORY_SETUP,
  output logic [7:0] DETECT_CONTROL,
  output logic INT_OUT,
  output logic INT_OE
);
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    accsl_pkg::accsl_slave_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic ptr_loaded;
    logic [7:0] ptr;
    logic sda_low;
    logic [7:0] sleep_control;
    logic [7:0] factory_setup;
    logic [7:0] detect_control;
    logic int_out;
    logic int_oe;
  } accsl_slave_regs_type;

  accsl_slave_regs_type r;
  accsl_slave_regs_type next_r;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd_data;

  // ************************************************************
  // register read decode
  // ************************************************************
  always_comb begin
    case (r.ptr) // [R18]
      `ACCSL_REG_XLOW: rd_data = X_ACCEL_RESULT[7:0]; // [R19] [R22]
      `ACCSL_REG_XHIGH: rd_data = {`ACCSL_HIGH_PAD, X_ACCEL_RESULT[11:8]}; // [R19] [R23]
      `ACCSL_REG_YLOW: rd_data = Y_ACCEL_RESULT[7:0]; // [R20]
      `ACCSL_REG_YHIGH: rd_data = {`ACCSL_HIGH_PAD, Y_ACCEL_RESULT[11:8]}; // [R20] [R23]
      `ACCSL_REG_STATUS: rd_data = STATUS_IN; // [R21]
      `ACCSL_REG_IDENT: rd_data = IDENT_VALUE; // [R21]
      default: rd_data = 8'h00; // write-only and unmapped read zero [R21] [R24]
    endcase
  end

  // ************************************************************
  // line sampling and protocol engine
  // ************************************************************
  always_comb begin
    next_r = r;
    next_r.scl_sync = {r.scl_sync[0], LINK.scl}; // [R02]
    next_r.sda_sync = {r.sda_sync[0], LINK.sda};
    next_r.scl_d = r.scl_sync[1];
    next_r.sda_d = r.sda_sync[1];
    scl_rise = r.scl_sync[1] && !r.scl_d;
    scl_fall = !r.scl_sync[1] && r.scl_d;
    start_seen = r.scl_sync[1] && r.scl_d && r.sda_d && !r.sda_sync[1]; // [R03]
    stop_seen = r.scl_sync[1] && r.scl_d && !r.sda_d && r.sda_sync[1]; // [R03]
    if (start_seen) begin
      next_r.state = accsl_pkg::SL_ADDR; // repeated start treated alike [R08]
      next_r.bit_cnt = 4'h0;
      next_r.sda_low = 1'b0;
    end else if (stop_seen) begin
      next_r.state = accsl_pkg::SL_IDLE;
      next_r.sda_low = 1'b0;
    end else begin
      case (r.state)
        accsl_pkg::SL_IDLE: next_r.sda_low = 1'b0;
        accsl_pkg::SL_ADDR, accsl_pkg::SL_WRITE: begin
          if (scl_rise) begin
            next_r.shift = {r.shift[6:0], r.sda_sync[1]}; // msb first [R04]
            next_r.bit_cnt = r.bit_cnt + 4'h1;
          end
          if (scl_fall && r.bit_cnt == `ACCSL_BYTE_BITS) begin
            next_r.bit_cnt = 4'h0;
            if (r.state == accsl_pkg::SL_ADDR) begin
              if (r.shift[7:1] == `ACCSL_DEV_ADDR) begin // [R01] [R09]
                next_r.rw = r.shift[0];
                next_r.ptr_loaded = 1'b0;
                next_r.sda_low = 1'b1; // [R10]
                next_r.state = accsl_pkg::SL_ACK;
              end else begin
                next_r.state = accsl_pkg::SL_IDLE;
              end
            end else begin
              next_r.sda_low = 1'b1; // ack every written byte [R05] [R24]
              next_r.state = accsl_pkg::SL_ACK;
              if (!r.ptr_loaded) begin
                next_r.ptr = r.shift; // [R11]
                next_r.ptr_loaded = 1'b1;
              end else begin
                case (r.ptr) // read-only and unmapped writes dropped [R21] [R24]
                  `ACCSL_REG_SLEEP: next_r.sleep_control = r.shift; // [R12]
                  `ACCSL_REG_FACTORY: next_r.factory_setup = r.shift;
                  `ACCSL_REG_DETECT: next_r.detect_control = r.shift;
                  default: next_r.sleep_control = r.sleep_control;
                endcase
                next_r.ptr = r.ptr + 8'h01; // [R12]
              end
            end
          end
        end
        accsl_pkg::SL_ACK: begin
          // ack held through the whole ninth pulse; on its fall released for writes, replaced by the first data bit for reads [R05]
          if (scl_fall) begin
            if (r.rw == `ACCSL_DIR_READ) begin
              next_r.shift = rd_data; // [R10] [R14]
              next_r.sda_low = !rd_data[7];
              next_r.bit_cnt = 4'h1;
              next_r.state = accsl_pkg::SL_READ;
            end else begin
              next_r.sda_low = 1'b0;
              next_r.state = accsl_pkg::SL_WRITE;
            end
          end
        end
        accsl_pkg::SL_READ: begin
          if (scl_fall) begin
            if (r.bit_cnt == `ACCSL_BYTE_BITS) begin
              next_r.sda_low = 1'b0; // transmitter releases for ack [R05]
              next_r.ptr = r.ptr + 8'h01; // [R14]
              next_r.state = accsl_pkg::SL_RACK;
            end else begin
              next_r.shift = {r.shift[6:0], 1'b0};
              next_r.sda_low = !r.shift[6]; // [R04]
              next_r.bit_cnt = r.bit_cnt + 4'h1;
            end
          end
        end
        accsl_pkg::SL_RACK: begin
          if (scl_rise) begin
            // nack ends the read; data stays released for stop or restart [R07]
            next_r.rw = !r.sda_sync[1];
          end
          if (scl_fall) begin
            if (r.rw) begin
              next_r.shift = rd_data;
              next_r.sda_low = !rd_data[7];
              next_r.bit_cnt = 4'h1;
              next_r.state = accsl_pkg::SL_READ;
            end else begin
              next_r.state = accsl_pkg::SL_IDLE;
            end
          end
        end
        default: next_r.state = accsl_pkg::SL_IDLE;
      endcase
    end
    // fault floats the pin; otherwise driven with the event level
    next_r.int_oe = !FAULT; // [R16]
    next_r.int_out = INT_EVENT && !FAULT; // [R15]
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      r <= '0;
      r.scl_sync <= 2'b11;
      r.sda_sync <= 2'b11;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      r.state <= accsl_pkg::SL_IDLE;
      r.rw <= 1'b1;
      r.sleep_control <= `ACCSL_CTRL_RESET;
      r.factory_setup <= `ACCSL_CTRL_RESET;
      r.detect_control <= `ACCSL_CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign LINK.sda_s_out = 1'b0; // open drain [R02]
  assign LINK.sda_s_oe = r.sda_low;
  assign SLEEP_CONTROL = r.sleep_control;
  assign FACTORY_SETUP = r.factory_setup;
  assign DETECT_CONTROL = r.detect_control;
  assign INT_OUT = r.int_out;
  assign INT_OE = r.int_oe;
endmodule // accsl_slave

// ==== verilog/accsl_master.sv ====
// master end: command driven two-wire bus master for the sensor
`timescale 1ns/1ps
`include "accsl_map.svh"
module accsl_master (
  input wire logic MCLK,
  input wire logic RSTN,
  accsl_if.master LINK,
  input wire logic CMD_VALID,
  input wire accsl_pkg::accsl_cmd_type CMD_KIND,
  input wire logic [7:0] CMD_REG,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_LAST,
  output logic CMD_READY,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic NACK_ERR,
  output logic BUSY
);
  typedef struct packed {
    logic [1:0] sda_sync;
    accsl_pkg::accsl_master_state_type state;
    logic [3:0] div;
    logic phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [1:0] byte_idx;
    logic reading;
    logic kind_rd;
    logic [7:0] reg_num;
    logic [7:0] wdata;
    logic last;
    logic scl_low;
    logic sda_low;
    logic cmd_ready;
    logic [7:0] rd_data;
    logic rd_valid;
    logic nack_err;
    logic busy;
  } accsl_master_regs_type;

  accsl_master_regs_type r;
  accsl_master_regs_type next_r;
  logic tick;
  logic sda_in;

  // ************************************************************
  // byte sequencing: address, pointer, data or restart+read
  // ************************************************************
  always_comb begin
    next_r = r;
    next_r.sda_sync = {r.sda_sync[0], LINK.sda};
    sda_in = r.sda_sync[1];
    next_r.rd_valid = 1'b0;
    next_r.cmd_ready = 1'b0;
    tick = (r.div == `ACCSL_SCL_HALF);
    next_r.div = tick ? 4'h0 : r.div + 4'h1;
    case (r.state)
      accsl_pkg::MS_IDLE: begin
        next_r.scl_low = 1'b0;
        next_r.sda_low = 1'b0;
        next_r.busy = 1'b0;
        // ready stands until a command is taken, so a held request cannot stall
        next_r.cmd_ready = !(CMD_VALID && r.cmd_ready);
        if (CMD_VALID && r.cmd_ready) begin
          next_r.busy = 1'b1;
          next_r.kind_rd = (CMD_KIND == accsl_pkg::ACCSL_CMD_READ);
          next_r.reg_num = CMD_REG;
          next_r.wdata = CMD_DATA;
          next_r.last = CMD_LAST;
          next_r.reading = 1'b0;
          next_r.byte_idx = 2'h0;
          next_r.nack_err = 1'b0;
          next_r.state = accsl_pkg::MS_START;
        end
      end
      accsl_pkg::MS_START: if (tick) begin
        next_r.sda_low = 1'b1; // falling data, clock high
        next_r.phase = 1'b0;
        next_r.shift = {`ACCSL_DEV_ADDR, r.reading};
        next_r.bit_cnt = 4'h0;
        next_r.state = accsl_pkg::MS_BIT;
      end
      accsl_pkg::MS_BIT: if (tick) begin
        // data moves one tick before the clock rises, never with it
        if (r.scl_low && !r.phase) begin
          next_r.sda_low = (r.reading && r.byte_idx != 2'h0) ? 1'b0 : !r.shift[7];
          next_r.phase = 1'b1;
        end else if (r.scl_low) begin
          next_r.scl_low = 1'b0;
        end else if (r.phase) begin
          next_r.shift = {r.shift[6:0], sda_in};
          next_r.bit_cnt = r.bit_cnt + 4'h1;
          next_r.scl_low = 1'b1;
          next_r.phase = 1'b0;
          if (r.bit_cnt == 4'h7) begin
            next_r.state = accsl_pkg::MS_ACK;
          end
        end else begin
          next_r.scl_low = 1'b1; // start hold before the first bit
        end
      end
      accsl_pkg::MS_ACK: if (tick) begin
        if (r.scl_low && !r.phase) begin
          if (r.reading && r.byte_idx != 2'h0) begin
            next_r.rd_data = r.shift;
            next_r.rd_valid = 1'b1;
            next_r.sda_low = !r.last; // nack the final read byte
          end else begin
            next_r.sda_low = 1'b0;
          end
          next_r.phase = 1'b1;
        end else if (r.scl_low) begin
          next_r.scl_low = 1'b0;
        end else begin
          next_r.scl_low = 1'b1;
          next_r.bit_cnt = 4'h0;
          next_r.phase = 1'b0;
          next_r.byte_idx = (r.byte_idx == 2'h3) ? 2'h3 : r.byte_idx + 2'h1;
          if (!(r.reading && r.byte_idx != 2'h0) && sda_in) begin
            next_r.nack_err = 1'b1; // abort with stop [R06]
            next_r.state = accsl_pkg::MS_STOP;
          end else if (r.reading && r.byte_idx != 2'h0) begin
            next_r.state = r.last ? accsl_pkg::MS_STOP : accsl_pkg::MS_BIT;
            next_r.last = 1'b1;
          end else if (r.byte_idx == 2'h0 && !r.reading) begin
            next_r.shift = r.reg_num;
            next_r.state = accsl_pkg::MS_BIT;
          end else if (r.reading) begin
            next_r.state = accsl_pkg::MS_BIT;
          end else if (r.kind_rd) begin
            next_r.state = accsl_pkg::MS_RESTART;
          end else if (r.byte_idx == 2'h1) begin
            next_r.shift = r.wdata;
            next_r.state = accsl_pkg::MS_BIT;
          end else begin
            next_r.state = accsl_pkg::MS_STOP;
          end
        end
      end
      accsl_pkg::MS_RESTART: if (tick) begin
        // release data then clock, then start again for reading
        next_r.sda_low = 1'b0;
        next_r.scl_low = r.sda_low;
        if (!r.sda_low && !r.scl_low) begin
          next_r.reading = 1'b1;
          next_r.byte_idx = 2'h0;
          next_r.state = accsl_pkg::MS_START;
        end
      end
      accsl_pkg::MS_STOP: if (tick) begin
        next_r.phase = !r.phase;
        if (!r.phase) begin
          next_r.sda_low = 1'b1;
        end else if (r.scl_low) begin
          next_r.scl_low = 1'b0;
        end else begin
          next_r.sda_low = 1'b0; // rising data, clock high
          next_r.state = accsl_pkg::MS_IDLE;
        end
      end
      default: next_r.state = accsl_pkg::MS_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      r <= '0;
      r.sda_sync <= 2'b11;
      r.state <= accsl_pkg::MS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign LINK.scl_out = 1'b0;
  assign LINK.scl_oe = r.scl_low;
  assign LINK.sda_m_out = 1'b0;
  assign LINK.sda_m_oe = r.sda_low;
  assign CMD_READY = r.cmd_ready;
  assign RD_DATA = r.rd_data;
  assign RD_VALID = r.rd_valid;
  assign NACK_ERR = r.nack_err;
  assign BUSY = r.busy;
endmodule // accsl_master

// ==== tb/accsl_chk.sv ====
// link checker: watches the two-wire lines between the master and the sensor port
`timescale 1ns/1ps
`include "accsl_map.svh"
module accsl_chk (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_out,
  input wire logic sda_s_oe
);
  // ********************
  // frame tracking
  // ********************
  logic scl_q, sda_q, first_byte, hit, dir, ack_hold, nacked;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [17:0] low_cnt;
  wire rise = scl && !scl_q;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire ninth = rise && bit_cnt == 4'h8;
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      {scl_q, sda_q} <= 2'h3;
      {first_byte, hit, dir, ack_hold, nacked} <= 5'h00;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      low_cnt <= 18'h00000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      low_cnt <= (!scl && !sda) ? low_cnt + 18'h00001 : 18'h00000;
      // ack seen at the ninth rise stays armed until the clock falls
      ack_hold <= scl && (ack_hold || (ninth && !sda));
      if (start || stop) begin
        bit_cnt <= 4'h0;
        first_byte <= start;
        nacked <= 1'b0;
        if (stop) hit <= 1'b0;
      end else if (rise) begin
        bit_cnt <= ninth ? 4'h0 : bit_cnt + 4'h1;
        if (!ninth) shift <= {shift[6:0], sda};
        if (ninth && first_byte) begin
          first_byte <= 1'b0;
          hit <= shift[7:1] == `ACCSL_DEV_ADDR;
          dir <= shift[0];
        end
        if (ninth && sda) nacked <= 1'b1;
      end
    end
  end
  // ********************
  // checks
  // ********************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  chk_slave_stable: assert property ((scl && scl_q) |-> $stable(sda_s_oe))
    else $error("slave data changed while clock high");
  chk_open_drain: assert property (sda_s_oe |-> !sda_s_out)
    else $error("slave data driven high");
  chk_addr_ack: assert property ((ninth && first_byte && shift[7:1] == `ACCSL_DEV_ADDR) |-> !sda)
    else $error("own address not acknowledged");
  chk_write_ack: assert property ((ninth && !first_byte && hit && !dir) |-> !sda)
    else $error("written byte not acknowledged");
  chk_ack_held: assert property ((ack_hold && scl) |-> !sda)
    else $error("acknowledge not held over ninth pulse");
  chk_nack_release: assert property (nacked |-> !sda_s_oe)
    else $error("slave drives data after a missing acknowledge");
  chk_stop_idle: assert property (stop |=> (scl && sda))
    else $error("bus not idle after stop");
  chk_idle_quiet: assert property ((!first_byte && !hit) |-> !sda_s_oe)
    else $error("slave drives data while not addressed");
  chk_low_limit: assert property (low_cnt < `ACCSL_LOW_LIMIT_CYC)
    else $error("both lines held low too long");
endmodule // accsl_chk

// ==== tb/testbench.sv ====
// self-checking bench: master and sensor port joined over the two-wire link
`timescale 1ns/1ps
`include "accsl_map.svh"
module testbench;
  localparam logic [7:0] ident = 8'h5a; // arbitrary identity value
  localparam int half = 4;
  localparam accsl_pkg::accsl_cmd_type wr = accsl_pkg::ACCSL_CMD_WRITE;
  logic mclk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_last = 1'b0;
  logic int_event = 1'b0, fault = 1'b0, bscl = 1'b1, bsda = 1'b1;
  accsl_pkg::accsl_cmd_type cmd_kind = wr;
  logic [7:0] cmd_reg = 8'h00, cmd_data = 8'h00, status_in = 8'h96;
  logic [11:0] x_res = 12'ha5c, y_res = 12'h3f1;
  wire logic [7:0] sleep_ctl, factory, detect, rd_data, sleep_b, factory_b, detect_b;
  wire logic cmd_ready, rd_valid, nack_err, busy, int_out, int_oe;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  logic [7:0] rd_q[$];
  accsl_if u_accsl_if ();
  accsl_if u_accsl_if_bad ();
  // second link: bench bit-bangs the master side, idle clock stands high
  assign u_accsl_if_bad.scl_out = 1'b0;
  assign u_accsl_if_bad.scl_oe = !bscl;
  assign u_accsl_if_bad.sda_m_out = 1'b0;
  assign u_accsl_if_bad.sda_m_oe = !bsda;
  accsl_master u_accsl_master (.MCLK(mclk), .RSTN(rstn), .LINK(u_accsl_if.master), .CMD_VALID(cmd_valid),
    .CMD_KIND(cmd_kind), .CMD_REG(cmd_reg), .CMD_DATA(cmd_data), .CMD_LAST(cmd_last), .CMD_READY(cmd_ready),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .NACK_ERR(nack_err), .BUSY(busy));
  accsl_slave #(.IDENT_VALUE(ident)) u_accsl_slave (.MCLK(mclk), .RSTN(rstn), .LINK(u_accsl_if.device),
    .X_ACCEL_RESULT(x_res), .Y_ACCEL_RESULT(y_res), .STATUS_IN(status_in), .INT_EVENT(int_event),
    .FAULT(fault), .SLEEP_CONTROL(sleep_ctl), .FACTORY_SETUP(factory), .DETECT_CONTROL(detect),
    .INT_OUT(int_out), .INT_OE(int_oe));
  accsl_slave #(.IDENT_VALUE(ident)) u_accsl_slave_bad (.MCLK(mclk), .RSTN(rstn), .LINK(u_accsl_if_bad.device),
    .X_ACCEL_RESULT(x_res), .Y_ACCEL_RESULT(y_res), .STATUS_IN(status_in), .INT_EVENT(int_event),
    .FAULT(fault), .SLEEP_CONTROL(sleep_b), .FACTORY_SETUP(factory_b), .DETECT_CONTROL(detect_b),
    .INT_OUT(), .INT_OE());
  accsl_chk u_accsl_chk (.MCLK(mclk), .RSTN(rstn), .scl(u_accsl_if.scl), .sda(u_accsl_if.sda),
    .sda_s_out(u_accsl_if.sda_s_out), .sda_s_oe(u_accsl_if.sda_s_oe));
  initial begin
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end
  // ********************
  // tasks
  // ********************
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d values, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic run_cmd(input accsl_pkg::accsl_cmd_type k, input logic [7:0] r, input logic [7:0] d,
      input logic last);
    int n;
    rd_q.delete();
    cmd_kind = k;
    cmd_reg = r;
    cmd_data = d;
    cmd_last = last;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      n++;
    end while ((busy !== 1'b0 || n < 3) && n < 3000);
    chk8({7'h00, nack_err}, 8'h00);
  endtask
  task automatic rd_chk(input logic [7:0] r, input logic last, input logic [7:0] e0, input logic [7:0] e1);
    run_cmd(accsl_pkg::ACCSL_CMD_READ, r, 8'h00, last);
    chk8(8'(rd_q.size()), last ? 8'h01 : 8'h02);
    chk8(rd_q.size() > 0 ? rd_q[0] : 8'hxx, e0);
    if (!last) chk8(rd_q.size() > 1 ? rd_q[1] : 8'hxx, e1);
  endtask
  task automatic bb_start();
    wait_cyc(2);
    bsda = 1'b1;
    wait_cyc(2);
    bscl = 1'b1;
    wait_cyc(half);
    bsda = 1'b0;
    wait_cyc(half);
    bscl = 1'b0;
  endtask
  task automatic bb_byte(input logic [7:0] b, input logic nack_exp);
    int i;
    for (i = 0; i < 9; i++) begin
      wait_cyc(2);
      bsda = (i == 8) ? 1'b1 : b[7 - i];
      wait_cyc(2);
      bscl = 1'b1;
      wait_cyc(half - 1);
      if (i == 8) chk8({7'h00, u_accsl_if_bad.sda}, {7'h00, nack_exp});
      wait_cyc(1);
      bscl = 1'b0;
    end
  endtask
  task automatic bb_stop();
    wait_cyc(2);
    bsda = 1'b0;
    wait_cyc(2);
    bscl = 1'b1;
    wait_cyc(half);
    bsda = 1'b1;
    wait_cyc(half);
  endtask
  // ********************
  // tests
  // ********************
  initial begin
    int i;
    logic [7:0] ra[10];
    logic [7:0] ea[10];
    ra = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h10, 8'h05};
    ea = '{x_res[7:0], {4'h0, x_res[11:8]}, y_res[7:0], {4'h0, y_res[11:8]}, status_in,
      8'h00, 8'h00, 8'h00, ident, 8'h00};
    wait_cyc(20);
    rstn = 1'b1;
    wait_cyc(3);
    chk8(sleep_ctl, 8'h00);
    chk8(factory, 8'h00);
    chk8(detect, 8'h00);
    chk8({6'h00, int_oe, int_out}, 8'h02);
    $display("reset test done");
    for (i = 0; i < 10; i++) rd_chk(ra[i], 1'b1, ea[i], 8'h00);
    rd_chk(8'h00, 1'b0, ea[0], ea[1]);
    rd_chk(8'h02, 1'b0, ea[2], ea[3]);
    rd_chk(8'hff, 1'b0, 8'h00, ea[0]);
    $display("register read test done");
    run_cmd(wr, 8'h07, 8'h9d, 1'b0);
    run_cmd(wr, 8'h08, 8'h0f, 1'b0);
    run_cmd(wr, 8'h0a, 8'h1e, 1'b0);
    run_cmd(wr, 8'h00, 8'hff, 1'b0);
    run_cmd(wr, 8'h10, 8'h00, 1'b0);
    chk8(sleep_ctl, 8'h9d);
    chk8(factory, 8'h0f);
    chk8(detect, 8'h1e);
    rd_chk(8'h00, 1'b1, ea[0], 8'h00);
    rd_chk(8'h10, 1'b1, ident, 8'h00);
    rd_chk(8'h07, 1'b1, 8'h00, 8'h00);
    $display("register write test done");
    int_event = 1'b1;
    wait_cyc(3);
    chk8({6'h00, int_oe, int_out}, 8'h03);
    fault = 1'b1;
    wait_cyc(3);
    chk8({7'h00, int_oe}, 8'h00);
    fault = 1'b0;
    int_event = 1'b0;
    wait_cyc(3);
    chk8({6'h00, int_oe, int_out}, 8'h02);
    $display("interrupt test done");
    bb_start();
    bb_byte(8'h28, 1'b1);
    bb_stop();
    bb_start();
    bb_byte({`ACCSL_DEV_ADDR, 1'b0}, 1'b0);
    bb_byte(8'h07, 1'b0);
    bb_byte(8'h3c, 1'b0);
    bb_byte(8'h0f, 1'b0);
    bb_start();
    bb_byte({`ACCSL_DEV_ADDR, 1'b0}, 1'b0);
    bb_byte(8'h0a, 1'b0);
    bb_byte(8'h1d, 1'b0);
    bb_stop();
    chk8(sleep_b, 8'h3c);
    chk8(factory_b, 8'h0f);
    chk8(detect_b, 8'h1d);
    $display("second link test done");
    test_done();
  end
endmodule // testbench
